// File: common/hslp_pkg.sv
// hub strap sampling and indicator polarity: shared constants and types
package hslp_pkg;

  localparam int unsigned AXI_ADDR_W = 8;
  localparam int unsigned AXI_DATA_W = 32;
  localparam int unsigned AXI_STRB_W = AXI_DATA_W / 8;

  // configuration-method select code that means strap-driven defaults
  localparam logic [1:0] CFG_INTERNAL = 2'h2;

  // register byte offsets
  localparam logic [AXI_ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] REG_PORT   = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] REG_POL    = 8'h0C;
  localparam int unsigned           CTRL_LANE  = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic {PH_SAMPLE, PH_RUN} hslp_phase_t;

  // software configuration, used when straps are not honoured
  typedef struct packed {
    logic [1:0] fixed_code;
    logic [1:0] disable_code;
    logic       multi_tt;
    logic       led_on;
  } hslp_ctrl_t;

  localparam int unsigned CTRL_W = $bits(hslp_ctrl_t);
  localparam hslp_ctrl_t  CTRL_RST = '{fixed_code:   2'h0,
                                       disable_code: 2'h0,
                                       multi_tt:     1'b0,
                                       led_on:       1'b0};

  typedef struct packed {
    logic [21:0] rsvd;
    logic        mtt_strap;
    logic        led_strap;
    logic [1:0]  fixed_strap;
    logic [1:0]  disable_strap;
    logic        internal;
    logic [1:0]  cfg_sel;
    logic        sampled;
  } hslp_status_t;

  typedef struct packed {
    logic [13:0] rsvd_hi;
    logic        multi_tt;
    logic        led_on;
    logic        rsvd_mid;
    logic [6:0]  fixed;
    logic        rsvd_lo;
    logic [6:0]  disabled;
  } hslp_port_t;

  typedef struct packed {
    logic [17:0] rsvd_hi;
    logic [5:0]  amber_high;
    logic        rsvd_lo;
    logic [6:0]  green_high;
  } hslp_pol_t;

  // 2-bit strap code to a fill of 0..3 ports counted from the first one
  function automatic logic [3:1] hslp_fill(input logic [1:0] code);
    return {code[1] & code[0], code[1], code[1] | code[0]};
  endfunction : hslp_fill

  function automatic logic hslp_hit(input logic [AXI_ADDR_W-1:0] addr,
                                    input logic [AXI_ADDR_W-1:0] off);
    return addr[AXI_ADDR_W-1:2] == off[AXI_ADDR_W-1:2];
  endfunction : hslp_hit

endpackage : hslp_pkg

// File: src/hslp_strap_decode.sv
// strap or software codes to port masks and indicator polarities
`timescale 1ns/10ps
module hslp_strap_decode
  import hslp_pkg::*;
(
  input  wire logic       internal_in,      // strap configuration selected
  input  wire logic [1:0] disable_strap_in, // sampled port-disable code
  input  wire logic [1:0] fixed_strap_in,   // sampled fixed-device code
  input  wire logic       led_strap_in,     // sampled indicator enable
  input  wire logic       mtt_strap_in,     // sampled multi-translator
  input  wire logic [1:0] sw_disable_in,    // software port-disable code
  input  wire logic [1:0] sw_fixed_in,      // software fixed-device code
  input  wire logic       sw_led_in,        // software indicator enable
  input  wire logic       sw_mtt_in,        // software multi-translator
  output logic      [7:1] port_disabled_out,// ports held disabled
  output logic      [7:1] port_fixed_out,   // non-removable ports
  output logic            indicator_on_out, // indicator support on
  output logic            multi_tt_out,     // per-port translators
  output logic      [7:1] green_high_out,   // green pin active high
  output logic      [7:2] amber_high_out    // amber pin active high
);

  logic [1:0] dis_code;
  logic [1:0] fix_code;
  logic [3:1] dis_fill;
  logic [3:1] fix_fill;

  assign dis_code = internal_in ? disable_strap_in : sw_disable_in;
  assign fix_code = internal_in ? fixed_strap_in : sw_fixed_in;
  assign dis_fill = hslp_fill(dis_code);
  assign fix_fill = hslp_fill(fix_code);

  // disabling counts down from the top port
  assign port_disabled_out = {dis_fill[1], dis_fill[2], dis_fill[3],
                              4'h0};
  assign port_fixed_out    = {4'h0, fix_fill};
  assign indicator_on_out  = internal_in ? led_strap_in : sw_led_in;
  assign multi_tt_out      = internal_in ? mtt_strap_in : sw_mtt_in;

  // each green strap bit low means that pin runs active high
  assign green_high_out = internal_in ?
    {3'h0, ~disable_strap_in[1], ~disable_strap_in[0],
     ~fixed_strap_in[1], ~fixed_strap_in[0]} :
    7'h00;
  assign amber_high_out = internal_in ?
    {5'h00, ~mtt_strap_in} : 6'h00;

endmodule : hslp_strap_decode

// File: src/hslp_led_drive.sv
// indicator pin levels from requests, polarity and gating
`timescale 1ns/10ps
module hslp_led_drive #(
  parameter int unsigned W = 7
) (
  input  wire logic [W-1:0] request_in,     // indicator wanted lit
  input  wire logic [W-1:0] active_high_in, // pin polarity per bit
  input  wire logic         enable_in,      // indicator support on
  input  wire logic [W-1:0] blank_in,       // port disabled, keep dark
  output logic      [W-1:0] level_out       // pin level to drive
);

  logic [W-1:0] lit;

  assign lit       = request_in & ~blank_in & {W{enable_in}};
  // dark pins sit at the inverse of their active level
  assign level_out = lit ~^ active_high_in;

endmodule : hslp_led_drive

// File: src/hslp_top.sv
// hub strap sampling, indicator pin drive and register slave
//
// Behaviour
// - straps honoured only when select reads 1,0
// - sample port-disable straps at reset release
// - disable 00: all ports on, G4 G3 high
// - disable 01: port 7 off, G4 high, G3 low
// - disable 10: ports 7,6 off, G4 low, G3 high
// - disable 11: ports 7..5 off, G4 G3 low
// - software config: greens 2 and 1 low
// - sample fixed-device straps at reset release
// - fixed 00: all removable, G2 G1 high
// - fixed 01: port 1 fixed, G2 high, G1 low
// - fixed 10: ports 1,2 fixed, G2 low, G1 high
// - fixed 11: ports 1..3 fixed, G2 G1 low
// - ambers 7..5 are active low
// - software config: amber 4 active low
// - sample indicator enable strap at release
// - enable strap 0 disables indicators entirely
// - amber 3 always active low
// - software config: amber 2 active low
// - sample multi-translator strap at release
// - translator strap sets mode and amber 2 polarity
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
module hslp_top
  import hslp_pkg::*;
(
  input  wire logic                  clk_sys_in,   // 50 MHz system clock
  input  wire logic                  nrst_in,      // sync reset, active low
  input  wire logic [1:0]            cfg_select_in,// configuration method
  // green indicator pins with straps
  input  wire logic [2:1]            port_ok_indicator_low_in,   // pin in
  output logic      [2:1]            port_ok_indicator_low_out,  // pin out
  output logic                       port_ok_indicator_low_oe_out, // oe
  input  wire logic [4:3]            port_ok_indicator_high_in,  // pin in
  output logic      [4:3]            port_ok_indicator_high_out, // pin out
  output logic                       port_ok_indicator_high_oe_out, // oe
  output logic      [7:5]            port_ok_indicator_upper_out, // pin out
  output logic                       port_ok_indicator_upper_oe_out, // oe
  // amber indicator pins
  output logic      [7:5]            port_warn_indicator_upper_out, // out
  output logic                       port_warn_indicator_upper_oe_out, // oe
  input  wire logic                  port4_warn_indicator_in,    // pin in
  output logic                       port4_warn_indicator_out,   // pin out
  output logic                       port4_warn_indicator_oe_out,// oe
  output logic                       port3_warn_indicator_out,   // pin out
  output logic                       port3_warn_indicator_oe_out,// oe
  input  wire logic                  port2_warn_indicator_in,    // pin in
  output logic                       port2_warn_indicator_out,   // pin out
  output logic                       port2_warn_indicator_oe_out,// oe
  // hub port logic side
  input  wire logic [7:1]            green_req_in, // light green per port
  input  wire logic [7:2]            amber_req_in, // light amber per port
  output logic      [7:1]            port_disabled_out, // disabled ports
  output logic      [7:1]            port_fixed_out,    // non-removable
  output logic                       indicator_on_out,  // indicators on
  output logic                       multi_tt_out,      // per-port tt
  output logic                       internal_cfg_out,  // straps in use
  output logic                       straps_valid_out,  // sampling done
  // AXI4-Lite slave
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,  // write address
  input  wire logic                  s_axi_awvalid, // write addr valid
  output logic                       s_axi_awready, // write addr ready
  input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,   // write data
  input  wire logic [AXI_STRB_W-1:0] s_axi_wstrb,   // byte enables
  input  wire logic                  s_axi_wvalid,  // write data valid
  output logic                       s_axi_wready,  // write data ready
  output logic      [1:0]            s_axi_bresp,   // write response
  output logic                       s_axi_bvalid,  // response valid
  input  wire logic                  s_axi_bready,  // response ready
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,  // read address
  input  wire logic                  s_axi_arvalid, // read addr valid
  output logic                       s_axi_arready, // read addr ready
  output logic      [AXI_DATA_W-1:0] s_axi_rdata,   // read data
  output logic      [1:0]            s_axi_rresp,   // read response
  output logic                       s_axi_rvalid,  // read data valid
  input  wire logic                  s_axi_rready   // read data ready
);

  typedef struct packed {
    hslp_phase_t           phase;
    logic [1:0]            cfg_sel;
    logic [1:0]            disable_strap;
    logic [1:0]            fixed_strap;
    logic                  led_strap;
    logic                  mtt_strap;
    hslp_ctrl_t            ctrl;
    logic                  aw_have;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic                  w_have;
    logic [AXI_DATA_W-1:0] wdata;
    logic [AXI_STRB_W-1:0] wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [AXI_DATA_W-1:0] rdata;
    logic [1:0]            rresp;
    logic                  pin_oe;
    logic [7:1]            green_lvl;
    logic [7:2]            amber_lvl;
    logic [7:1]            disabled;
    logic [7:1]            fixed;
    logic                  led_on;
    logic                  multi_tt;
  } hslp_state_t;

  localparam hslp_state_t ST_RST = '{
    phase:         PH_SAMPLE,
    cfg_sel:       2'h0,
    disable_strap: 2'h0,
    fixed_strap:   2'h0,
    led_strap:     1'b0,
    mtt_strap:     1'b0,
    ctrl:          CTRL_RST,
    aw_have:       1'b0,
    awaddr:        '0,
    w_have:        1'b0,
    wdata:         '0,
    wstrb:         '0,
    bvalid:        1'b0,
    bresp:         RESP_OKAY,
    rvalid:        1'b0,
    rdata:         '0,
    rresp:         RESP_OKAY,
    pin_oe:        1'b0,
    green_lvl:     7'h00,
    amber_lvl:     6'h00,
    disabled:      7'h00,
    fixed:         7'h00,
    led_on:        1'b0,
    multi_tt:      1'b0
  };

  hslp_state_t s_r;
  hslp_state_t s_nxt;

  logic         internal;
  logic [7:1]   dis_w;
  logic [7:1]   fix_w;
  logic         led_w;
  logic         mtt_w;
  logic [7:1]   green_high_w;
  logic [7:2]   amber_high_w;
  logic [7:1]   green_lvl_w;
  logic [7:2]   amber_lvl_w;
  hslp_status_t status_w;
  hslp_port_t   port_w;
  hslp_pol_t    pol_w;

  assign internal = s_r.cfg_sel == CFG_INTERNAL;

  hslp_strap_decode u_decode (
    .internal_in       (internal),
    .disable_strap_in  (s_r.disable_strap),
    .fixed_strap_in    (s_r.fixed_strap),
    .led_strap_in      (s_r.led_strap),
    .mtt_strap_in      (s_r.mtt_strap),
    .sw_disable_in     (s_r.ctrl.disable_code),
    .sw_fixed_in       (s_r.ctrl.fixed_code),
    .sw_led_in         (s_r.ctrl.led_on),
    .sw_mtt_in         (s_r.ctrl.multi_tt),
    .port_disabled_out (dis_w),
    .port_fixed_out    (fix_w),
    .indicator_on_out  (led_w),
    .multi_tt_out      (mtt_w),
    .green_high_out    (green_high_w),
    .amber_high_out    (amber_high_w)
  );

  hslp_led_drive #(
    .W (7)
  ) u_green (
    .request_in     (green_req_in),
    .active_high_in (green_high_w),
    .enable_in      (led_w),
    .blank_in       (dis_w),
    .level_out      (green_lvl_w)
  );

  hslp_led_drive #(
    .W (6)
  ) u_amber (
    .request_in     (amber_req_in),
    .active_high_in (amber_high_w),
    .enable_in      (led_w),
    .blank_in       (dis_w[7:2]),
    .level_out      (amber_lvl_w)
  );

  // read-back words
  always_comb
  begin
    status_w               = '0;
    status_w.mtt_strap     = s_r.mtt_strap;
    status_w.led_strap     = s_r.led_strap;
    status_w.fixed_strap   = s_r.fixed_strap;
    status_w.disable_strap = s_r.disable_strap;
    status_w.internal      = internal;
    status_w.cfg_sel       = s_r.cfg_sel;
    status_w.sampled       = s_r.phase == PH_RUN;
    port_w                 = '0;
    port_w.multi_tt        = s_r.multi_tt;
    port_w.led_on          = s_r.led_on;
    port_w.fixed           = s_r.fixed;
    port_w.disabled        = s_r.disabled;
    pol_w                  = '0;
    pol_w.amber_high       = amber_high_w;
    pol_w.green_high       = green_high_w;
  end

  assign s_axi_awready = ~s_r.aw_have & ~s_r.bvalid;
  assign s_axi_wready  = ~s_r.w_have & ~s_r.bvalid;
  assign s_axi_arready = ~s_r.rvalid;

  always_comb
  begin
    s_nxt = s_r;

    // straps are taken once, on the first clock after reset release,
    // while every shared pin is still released
    unique case (s_r.phase)
      PH_SAMPLE:
      begin
        s_nxt.cfg_sel       = cfg_select_in;
        s_nxt.disable_strap = port_ok_indicator_high_in;
        s_nxt.fixed_strap   = port_ok_indicator_low_in;
        s_nxt.led_strap     = port4_warn_indicator_in;
        s_nxt.mtt_strap     = port2_warn_indicator_in;
        s_nxt.phase         = PH_RUN;
      end
      PH_RUN:
      begin
        s_nxt.pin_oe = 1'b1;
      end
    endcase

    s_nxt.green_lvl = green_lvl_w;
    s_nxt.amber_lvl = amber_lvl_w;
    s_nxt.disabled  = dis_w;
    s_nxt.fixed     = fix_w;
    s_nxt.led_on    = led_w;
    s_nxt.multi_tt  = mtt_w;

    // write channel: address and data may come in either order
    if (s_r.bvalid && s_axi_bready)
    begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_nxt.aw_have = 1'b1;
      s_nxt.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_nxt.w_have = 1'b1;
      s_nxt.wdata  = s_axi_wdata;
      s_nxt.wstrb  = s_axi_wstrb;
    end
    if (s_nxt.aw_have && s_nxt.w_have)
    begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = RESP_OKAY;
      if (hslp_hit(s_nxt.awaddr, REG_CTRL))
      begin
        if (s_nxt.wstrb[CTRL_LANE])
        begin
          s_nxt.ctrl = hslp_ctrl_t'(s_nxt.wdata[CTRL_W-1:0]);
        end
      end
      else if (!hslp_hit(s_nxt.awaddr, REG_STATUS) &&
               !hslp_hit(s_nxt.awaddr, REG_PORT) &&
               !hslp_hit(s_nxt.awaddr, REG_POL))
      begin
        s_nxt.bresp = RESP_DECERR;
      end
    end

    // read channel: one answer outstanding at a time
    if (s_r.rvalid && s_axi_rready)
    begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = RESP_OKAY;
      if (hslp_hit(s_axi_araddr, REG_CTRL))
      begin
        s_nxt.rdata = AXI_DATA_W'(s_r.ctrl);
      end
      else if (hslp_hit(s_axi_araddr, REG_STATUS))
      begin
        s_nxt.rdata = status_w;
      end
      else if (hslp_hit(s_axi_araddr, REG_PORT))
      begin
        s_nxt.rdata = port_w;
      end
      else if (hslp_hit(s_axi_araddr, REG_POL))
      begin
        s_nxt.rdata = pol_w;
      end
      else
      begin
        s_nxt.rdata = '0;
        s_nxt.rresp = RESP_DECERR;
      end
    end
  end

  // straps stay put until the next reset; nothing else reloads them
  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in)
    begin
      s_r <= ST_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // pins only turn to outputs once sampling is over
  assign port_ok_indicator_low_out        = s_r.green_lvl[2:1];
  assign port_ok_indicator_low_oe_out     = s_r.pin_oe;
  assign port_ok_indicator_high_out       = s_r.green_lvl[4:3];
  assign port_ok_indicator_high_oe_out    = s_r.pin_oe;
  assign port_ok_indicator_upper_out      = s_r.green_lvl[7:5];
  assign port_ok_indicator_upper_oe_out   = s_r.pin_oe;
  assign port_warn_indicator_upper_out    = s_r.amber_lvl[7:5];
  assign port_warn_indicator_upper_oe_out = s_r.pin_oe;
  assign port4_warn_indicator_out         = s_r.amber_lvl[4];
  assign port4_warn_indicator_oe_out      = s_r.pin_oe;
  assign port3_warn_indicator_out         = s_r.amber_lvl[3];
  assign port3_warn_indicator_oe_out      = s_r.pin_oe;
  assign port2_warn_indicator_out         = s_r.amber_lvl[2];
  assign port2_warn_indicator_oe_out      = s_r.pin_oe;

  assign port_disabled_out = s_r.disabled;
  assign port_fixed_out    = s_r.fixed;
  assign indicator_on_out  = s_r.led_on;
  assign multi_tt_out      = s_r.multi_tt;
  assign internal_cfg_out  = internal;
  assign straps_valid_out  = s_r.phase == PH_RUN;

  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp  = s_r.bresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata  = s_r.rdata;
  assign s_axi_rresp  = s_r.rresp;

endmodule : hslp_top

// File: verif/hslp_board.sv
// board strap resistors and shared indicator pin wiring
`timescale 1ns/10ps
module hslp_board
(
  input  wire logic [5:0] strap_in, // strap resistor levels
  input  wire logic [5:0] dout_in,  // device pin drive levels
  input  wire logic [3:0] oe_in,    // device enables per pin group
  output logic      [5:0] pin_out   // resolved pin levels
);
  logic [5:0] en;

  assign en = {oe_in[3:2], {2{oe_in[1]}}, {2{oe_in[0]}}};
  // a released pin falls back to its resistor, never to a stale level
  assign pin_out = (dout_in & en) | (strap_in & ~en);
endmodule : hslp_board

// File: verif/hslp_top_monitor.sv
// assertions on strap capture, mask decode and indicator levels
`timescale 1ns/10ps
module hslp_top_monitor
  import hslp_pkg::*;
(
  input wire logic       clk_sys_in, // clock
  input wire logic       nrst_in, // reset
  input wire logic [1:0] cfg_select_in, // method
  input wire logic [2:1] port_ok_indicator_low_in, // pin
  input wire logic [2:1] port_ok_indicator_low_out, // drive
  input wire logic       port_ok_indicator_low_oe_out, // oe
  input wire logic [4:3] port_ok_indicator_high_in, // pin
  input wire logic [4:3] port_ok_indicator_high_out, // drive
  input wire logic       port_ok_indicator_high_oe_out, // oe
  input wire logic [7:5] port_ok_indicator_upper_out, // drive
  input wire logic [7:5] port_warn_indicator_upper_out, // drive
  input wire logic       port4_warn_indicator_in, // pin
  input wire logic       port4_warn_indicator_out, // drive
  input wire logic       port4_warn_indicator_oe_out, // oe
  input wire logic       port3_warn_indicator_out, // drive
  input wire logic       port2_warn_indicator_in, // pin
  input wire logic       port2_warn_indicator_out, // drive
  input wire logic       port2_warn_indicator_oe_out, // oe
  input wire logic [7:1] green_req_in, // request
  input wire logic [7:2] amber_req_in, // request
  input wire logic [7:1] port_disabled_out, // mask
  input wire logic [7:1] port_fixed_out, // mask
  input wire logic       indicator_on_out, // mode
  input wire logic       multi_tt_out, // mode
  input wire logic       internal_cfg_out, // mode
  input wire logic       straps_valid_out // sampled
);
  logic [1:0] cfg_r, dis_r, fix_r;
  logic       led_r, mtt_r, arm_r, ok_r;
  logic [7:1] gq_r;
  logic [7:2] aq_r;
  wire        int_w = cfg_r == 2'h2;
  wire        oe_all = port_ok_indicator_low_oe_out &
    port_ok_indicator_high_oe_out & port4_warn_indicator_oe_out &
    port2_warn_indicator_oe_out;
  // masks register with the pins, so only requests are held back
  wire [7:1]  g_w = gq_r & ~port_disabled_out & {7{indicator_on_out}};
  wire [7:2]  a_w = aq_r & ~port_disabled_out[7:2] & {6{indicator_on_out}};

  always_ff @(posedge clk_sys_in)
  begin
    arm_r <= !nrst_in;
    ok_r  <= nrst_in & oe_all;
    gq_r  <= green_req_in;
    aq_r  <= amber_req_in;
    if (nrst_in && arm_r)
    begin
      cfg_r <= cfg_select_in;
      dis_r <= port_ok_indicator_high_in;
      fix_r <= port_ok_indicator_low_in;
      led_r <= port4_warn_indicator_in;
      mtt_r <= port2_warn_indicator_in;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  sequence s_sampled;
    $rose(straps_valid_out);
  endsequence
  sequence s_driven;
    !port2_warn_indicator_oe_out ##1 oe_all;
  endsequence

  chk_drive_late: assert property (s_sampled |-> s_driven)
    else $error("pins driven before strap capture");
  chk_sel_decode: assert property (
    straps_valid_out |-> internal_cfg_out == int_w)
    else $error("config method decode wrong");
  chk_port_disable: assert property (
    ok_r && int_w |-> port_disabled_out == {|dis_r, dis_r[1], &dis_r, 4'h0})
    else $error("disabled port mask wrong");
  chk_port_fixed: assert property (
    ok_r && int_w |-> port_fixed_out == {4'h0, &fix_r, fix_r[1], |fix_r})
    else $error("fixed device mask wrong");
  chk_strap_modes: assert property (
    ok_r && int_w |-> indicator_on_out == led_r && multi_tt_out == mtt_r)
    else $error("strap mode outputs wrong");
  chk_green_pol: assert property (
    ok_r |-> {port_ok_indicator_high_out, port_ok_indicator_low_out} ==
    ~(g_w[4:1] ^ (~{dis_r, fix_r} & {4{int_w}})))
    else $error("green level wrong");
  chk_upper_low: assert property (
    ok_r |-> {port_ok_indicator_upper_out, port_warn_indicator_upper_out} ==
    ~{g_w[7:5], a_w[7:5]})
    else $error("upper indicator level wrong");
  chk_amber_mid: assert property (
    ok_r |-> {port4_warn_indicator_out, port3_warn_indicator_out} == ~a_w[4:3])
    else $error("amber 4 or 3 level wrong");
  chk_amber2_pol: assert property (
    ok_r |-> port2_warn_indicator_out == ~(a_w[2] ^ (int_w & ~mtt_r)))
    else $error("amber 2 level wrong");
endmodule : hslp_top_monitor

bind hslp_top hslp_top_monitor u_mon (.*);

// File: verif/hslp_top_test.sv
// strap sampling and register readback tests for the hub indicator block
`timescale 1ns/10ps
module hslp_top_test;
  import hslp_pkg::*;
  logic                  clk_sys_in, nrst_in;
  logic [1:0]            cfg_select_in, s_axi_bresp, s_axi_rresp, rr;
  logic [2:1]            port_ok_indicator_low_in, port_ok_indicator_low_out;
  logic [4:3]            port_ok_indicator_high_in, port_ok_indicator_high_out;
  logic [7:5]            port_ok_indicator_upper_out;
  logic [7:5]            port_warn_indicator_upper_out;
  logic                  port_ok_indicator_low_oe_out;
  logic                  port_ok_indicator_high_oe_out;
  logic                  port_ok_indicator_upper_oe_out;
  logic                  port_warn_indicator_upper_oe_out;
  logic                  port4_warn_indicator_in, port4_warn_indicator_out;
  logic                  port4_warn_indicator_oe_out, port3_warn_indicator_out;
  logic                  port3_warn_indicator_oe_out, port2_warn_indicator_in;
  logic                  port2_warn_indicator_out, port2_warn_indicator_oe_out;
  logic [7:1]            green_req_in, port_disabled_out, port_fixed_out;
  logic [7:2]            amber_req_in;
  logic                  indicator_on_out, multi_tt_out;
  logic                  internal_cfg_out, straps_valid_out;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [AXI_DATA_W-1:0] s_axi_wdata, s_axi_rdata, rd;
  logic [AXI_STRB_W-1:0] s_axi_wstrb;
  logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                  s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                  s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic                  s_axi_rready;
  logic [5:0]            st;
  int                    mismatches, n_compared;

  hslp_top DUT (.*);
  hslp_board u_board (
    .strap_in (st),
    .dout_in  ({port2_warn_indicator_out, port4_warn_indicator_out,
                port_ok_indicator_low_out, port_ok_indicator_high_out}),
    .oe_in    ({port2_warn_indicator_oe_out, port4_warn_indicator_oe_out,
                port_ok_indicator_low_oe_out, port_ok_indicator_high_oe_out}),
    .pin_out  ({port2_warn_indicator_in, port4_warn_indicator_in,
                port_ok_indicator_low_in, port_ok_indicator_high_in})
  );

  initial
  begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    @(posedge clk_sys_in);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge clk_sys_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge clk_sys_in);
    s_axi_araddr  <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge clk_sys_in);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // straps change only under reset
  task automatic boot(input logic [1:0] c, input logic [5:0] s);
    @(posedge clk_sys_in);
    {nrst_in, cfg_select_in, st} <= {1'b0, c, s};
    repeat (8) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
  endtask : boot

  function automatic logic [31:0] e_port(input logic [1:0] d, f,
                                         input logic l, m);
    return {14'h0, m, l, 1'b0, 4'h0, &f, f[1], |f,
            1'b0, |d, d[1], &d, 4'h0};
  endfunction : e_port

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  initial
  begin
    {mismatches, n_compared} = '0;
    {nrst_in, cfg_select_in, st} = '0;
    {green_req_in, amber_req_in} = '1;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid,
     s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    for (int i = 0; i < 4; i++)
    begin
      boot(2'h2, {i[1], i[0], 2'(3 - i), i[1:0]});
      axi_rd(REG_STATUS, rd, rr);
      chk(rd, {22'h0, st, 1'b1, 2'h2, 1'b1});
      axi_wr(REG_CTRL, 32'h3F, 4'hF, rr);
      axi_rd(REG_PORT, rd, rr);
      chk(rd, e_port(st[1:0], st[3:2], st[4], st[5]));
      axi_rd(REG_POL, rd, rr);
      chk(rd, {23'h0, ~st[5], 4'h0, ~st[1:0], ~st[3:2]});
      green_req_in <= ~green_req_in;
      amber_req_in <= ~amber_req_in;
    end
    for (int k = 0; k < 4; k++)
    begin
      boot({k == 2, k != 0}, 6'h3F);
      axi_wr(REG_CTRL, {26'h0, ~k[1:0], k[1:0], k[1], ~k[0]}, 4'h1, rr);
      chk(rr, RESP_OKAY);
      axi_wr(REG_CTRL, 32'h0, 4'hE, rr);
      axi_rd(REG_PORT, rd, rr);
      chk(rd, e_port(k[1:0], ~k[1:0], ~k[0], k[1]));
      axi_wr(REG_POL, 32'hFFFFFFFF, 4'hF, rr);
      axi_rd(REG_POL, rd, rr);
      chk(rd, 32'h0);
      green_req_in <= ~green_req_in;
    end
    axi_rd(8'h10, rd, rr);
    chk(rd, 32'h0);
    chk(rr, RESP_DECERR);
    conclude();
  end

  // run needs a few hundred cycles; wide margin
  initial
  begin
    #400000;
    mismatches++;
    conclude();
  end
endmodule : hslp_top_test
